// *** common/csv_pkg.sv ***
// Package: constants and carrier types for current scaling and velocity mode select
package csv_pkg;
  // Timing counts
  localparam int unsigned CSV_STST_CLOCKS = 1 << 20; // Clocks from last step to standstill
  localparam int unsigned CSV_RAMP_UNIT_CLOCKS = 1 << 18; // Clocks per ramp delay unit
  localparam logic [19:0] CSV_STEP_INTERVAL_MEASURE_MAX = 20'h F_FFFF; // Interval on overflow or standstill
  localparam int unsigned CSV_STEP_INTERVAL_MEASURE_W = 20; // Interval width
  // Reset values
  localparam logic [4:0] CSV_CS_RESET = 5'h00; // Actual scale after reset
  localparam logic [8:0] CSV_GLOBAL_FULL = 9'h100; // Scaler zero means 256
  // Microstep resolution code: 0 = 256 per full step, n = 256 >> n
  localparam int unsigned CSV_MRES_W = 4;
  localparam logic [3:0] CSV_MRES_MAX = 4'h8; // Full step

  // Configuration carried into the block
  typedef struct packed {
    logic [4:0] run_current_scale;
    logic [4:0] hold_current_scale;
    logic [3:0] hold_ramp_step_delay;
    logic [7:0] standstill_wait_time;
    logic [7:0] global_current_scaler;
    logic [19:0] quiet_mode_interval_limit;
    logic [19:0] high_speed_interval_limit;
    logic [19:0] load_adapt_interval_limit;
    logic small_hysteresis;
    logic quiet_mode_cfg;
    logic load_adapt_cfg;
    logic [3:0] mres;
  } csv_cfg_t;

  // Mode results
  typedef struct packed {
    logic quiet_mode_en;
    logic load_adapt_en;
    logic high_speed;
  } csv_mode_t;
endpackage : csv_pkg

// *** hdl/csv_thresh_cmp.sv ***
// Module: one interval threshold comparator with hysteresis
`timescale 1ns/1ps
module csv_thresh_cmp
  import csv_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic upd, // New interval available
  input wire logic [19:0] step_interval,
  input wire logic [19:0] limit,
  input wire logic small_hysteresis,
  output logic fast // Velocity above threshold
);
  import csv_pkg::*;

  logic [19:0] hyst; // Hysteresis amount in clocks
  logic [20:0] upper_iv; // Interval plus hysteresis, one bit wider

  // Hysteresis amount: 1/16 or 1/32 of the interval
  always_comb begin
    hyst = small_hysteresis ? (step_interval >> 5) : (step_interval >> 4);
  end

  // Upper switching point: interval must undercut limit by the hysteresis
  always_comb begin
    upper_iv = {1'b0, step_interval} + {1'b0, hyst};
  end

  // Switch up only past upper point, down exactly at threshold
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fast <= 1'b0;
    end else if (upd) begin
      if (!fast && upper_iv < {1'b0, limit}) begin
        fast <= 1'b1;
      end else if (fast && step_interval >= limit) begin
        fast <= 1'b0;
      end
    end
  end

  // Inside the band a slow result stays slow
  upper_point_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (upd && !fast && upper_iv >= {1'b0, limit}) |=> !fast) else $error("early switch up");

  // Low threshold return holds at the limit itself
  lower_point_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (upd && fast && step_interval >= limit) |=> !fast) else $error("no drop at threshold");
endmodule : csv_thresh_cmp

// *** hdl/csv_current_mode.sv ***
// Module: current scaling, standstill power down and velocity mode select
//
// Notes on behaviour
// - Running current uses run scale, 1..32/32.
// - Run scale caps load-adaptive scale choice.
// - Standstill current uses hold scale.
// - Ramp starts after wait; delay zero instant.
// - Each step waits delay times 2^18 clocks.
// - Global scaler in 1/256, zero is full.
// - Velocity is clocks between step pulses.
// - Interval normalised to 256 microsteps.
// - Interval vs three limits picks modes.
// - Hysteresis 1/16 or 1/32 by bit.
// - Upper point above threshold; lower equal.
// - Standstill flag picks run or hold scale.
// - Standstill flag after 2^20 clocks idle.
// - Overflow or standstill reads maximum interval.
// - Interval at or above quiet limit: quiet mode.
// - Between high and adapt limits: load adapt.
`timescale 1ns/1ps
module csv_current_mode
  import csv_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire csv_pkg::csv_cfg_t cfg, // Configuration bits
  input wire logic step_pulse, // One-cycle step event
  input wire logic [4:0] adapt_scale_req, // Scale wanted by load-adaptive control
  input wire logic [7:0] sine_value, // Coil value from sine table
  output logic [4:0] actual_scale, // Current scale in use
  output logic scale_update, // Pulse when actual_scale changes
  output logic [15:0] coil_current, // Scaled coil current
  output logic [8:0] global_scale, // Effective global scaler 1..256
  output logic standstill, // Standstill flag
  output logic [19:0] step_interval_measure, // Normalised interval
  output csv_pkg::csv_mode_t mode // Mode selections
);
  import csv_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Step interval measurement

  logic [27:0] raw_count; // Clocks since last step, raw resolution
  logic [27:0] norm_raw; // Raw count normalised to 256 microsteps
  logic [20:0] idle_count; // Clocks since last step for standstill
  logic interval_upd; // New interval latched
  logic [3:0] mres_eff; // Clamped resolution code

  // Clamp resolution code to full step
  always_comb begin
    mres_eff = (cfg.mres > CSV_MRES_MAX) ? CSV_MRES_MAX : cfg.mres;
  end

  // Coarser steps span more 1/256 units: divide
  always_comb begin
    norm_raw = raw_count >> mres_eff;
  end

  // Raw counter saturates rather than wrapping
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      raw_count <= 28'h000_0000;
    end else if (step_pulse) begin
      raw_count <= 28'h000_0001;
    end else if (raw_count != 28'h FFF_FFFF) begin
      raw_count <= raw_count + 28'h000_0001;
    end
  end

  // Idle count for standstill detection
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      idle_count <= 21'(CSV_STST_CLOCKS);
    end else if (step_pulse) begin
      idle_count <= 21'h00_0000;
    end else if (idle_count < 21'(CSV_STST_CLOCKS)) begin
      idle_count <= idle_count + 21'h00_0001;
    end
  end

  // Standstill flag
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      standstill <= 1'b1;
    end else begin
      standstill <= !step_pulse && (idle_count + 21'h00_0001 >= 21'(CSV_STST_CLOCKS));
    end
  end

  // Interval latched per step, max on overflow or standstill
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      step_interval_measure <= CSV_STEP_INTERVAL_MEASURE_MAX;
      interval_upd <= 1'b0;
    end else begin
      interval_upd <= step_pulse || standstill || (norm_raw >= 28'(CSV_STEP_INTERVAL_MEASURE_MAX)); // Pulse on each latch
      if (step_pulse && !standstill) begin
        step_interval_measure <= (norm_raw > 28'(CSV_STEP_INTERVAL_MEASURE_MAX)) ? CSV_STEP_INTERVAL_MEASURE_MAX : norm_raw[19:0];
      end else if (standstill || norm_raw >= 28'(CSV_STEP_INTERVAL_MEASURE_MAX)) begin
        step_interval_measure <= CSV_STEP_INTERVAL_MEASURE_MAX;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Threshold comparisons

  logic [2:0] fast_v; // Above quiet, high, adapt velocities
  logic [19:0] limits [3]; // Limits per comparator

  always_comb begin
    limits[0] = cfg.quiet_mode_interval_limit;
    limits[1] = cfg.high_speed_interval_limit;
    limits[2] = cfg.load_adapt_interval_limit;
  end

  // One hysteresis comparator per limit
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_cmp
      csv_thresh_cmp u_cmp (
        .mclk(mclk),
        .rst_n(rst_n),
        .upd(interval_upd),
        .step_interval(step_interval_measure),
        .limit(limits[gi]),
        .small_hysteresis(cfg.small_hysteresis),
        .fast(fast_v[gi])
      );
    end
  endgenerate

  // Mode decisions from comparator states
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= '0;
    end else begin
      mode.quiet_mode_en <= cfg.quiet_mode_cfg && !fast_v[0] && !fast_v[1];
      mode.load_adapt_en <= cfg.load_adapt_cfg && fast_v[2] && !fast_v[1];
      mode.high_speed <= fast_v[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Standstill power down ramp

  typedef enum logic [1:0] {CSV_RUN, CSV_WAIT, CSV_RAMP, CSV_HOLD} csv_pd_t;
  csv_pd_t pd_state; // Power down phase
  logic [33:0] pd_timer; // Wait and step timer
  logic [4:0] ramp_scale; // Scale during ramp
  logic [33:0] wait_clocks; // Standstill wait in clocks
  logic [33:0] step_clocks; // Per step delay in clocks

  always_comb begin
    wait_clocks = 34'(cfg.standstill_wait_time) * 34'(CSV_RAMP_UNIT_CLOCKS);
    step_clocks = 34'(cfg.hold_ramp_step_delay) * 34'(CSV_RAMP_UNIT_CLOCKS);
  end

  // Phase sequencer: run, wait, ramp, hold
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pd_state <= CSV_RUN;
      pd_timer <= 34'h0_0000_0000;
      ramp_scale <= CSV_CS_RESET;
    end else if (!standstill) begin
      pd_state <= CSV_RUN;
      pd_timer <= 34'h0_0000_0000;
      ramp_scale <= cfg.run_current_scale;
    end else begin
      case (pd_state)
        CSV_RUN: begin
          pd_state <= CSV_WAIT;
          pd_timer <= 34'h0_0000_0000;
        end
        CSV_WAIT: begin
          if (pd_timer >= wait_clocks) begin
            pd_timer <= 34'h0_0000_0000;
            if (cfg.hold_ramp_step_delay == 4'h0 || ramp_scale <= cfg.hold_current_scale) begin
              pd_state <= CSV_HOLD;
            end else begin
              pd_state <= CSV_RAMP;
            end
          end else begin
            pd_timer <= pd_timer + 34'h0_0000_0001;
          end
        end
        CSV_RAMP: begin
          if (cfg.hold_ramp_step_delay == 4'h0 || ramp_scale <= cfg.hold_current_scale) begin
            pd_state <= CSV_HOLD;
          end else if (pd_timer + 34'h0_0000_0001 >= step_clocks) begin
            pd_timer <= 34'h0_0000_0000;
            ramp_scale <= ramp_scale - 5'h01;
          end else begin
            pd_timer <= pd_timer + 34'h0_0000_0001;
          end
        end
        CSV_HOLD: begin
          ramp_scale <= cfg.hold_current_scale;
        end
        default: begin
          pd_state <= CSV_RUN;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Actual scale and current path

  logic [4:0] next_actual_scale; // Scale chosen this cycle

  // Run path honours adaptive request under run ceiling
  always_comb begin
    if (!standstill || pd_state == CSV_RUN || pd_state == CSV_WAIT) begin
      if (mode.load_adapt_en && adapt_scale_req < cfg.run_current_scale) begin
        next_actual_scale = adapt_scale_req;
      end else begin
        next_actual_scale = cfg.run_current_scale;
      end
    end else if (pd_state == CSV_HOLD) begin
      next_actual_scale = cfg.hold_current_scale;
    end else begin
      next_actual_scale = ramp_scale;
    end
  end

  // Register the scale and flag changes
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      actual_scale <= CSV_CS_RESET;
      scale_update <= 1'b0;
    end else begin
      actual_scale <= next_actual_scale;
      scale_update <= (next_actual_scale != actual_scale);
    end
  end

  // Effective global scaler, zero is full scale
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      global_scale <= CSV_GLOBAL_FULL;
    end else begin
      global_scale <= (cfg.global_current_scaler == 8'h00) ? CSV_GLOBAL_FULL : {1'b0, cfg.global_current_scaler};
    end
  end

  // Coil value times (scale+1)/32 times global/256
  logic [30:0] prod; // Full product
  always_comb begin
    prod = 31'(sine_value) * 31'({1'b0, actual_scale} + 6'h01) * 31'(global_scale);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      coil_current <= 16'h0000;
    end else begin
      coil_current <= prod[28:13];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  sequence idle_long_s;
    !step_pulse [*8];
  endsequence

  stst_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
    step_pulse |=> !standstill) else $error("standstill after step");
  stst_max_a: assert property (@(posedge mclk) disable iff (!rst_n)
    standstill ##1 idle_long_s |-> step_interval_measure == CSV_STEP_INTERVAL_MEASURE_MAX) else $error("interval not max");
  hold_scale_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (pd_state == CSV_HOLD && standstill) |=> actual_scale == $past(cfg.hold_current_scale)) else $error("hold scale");
  run_cap_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !standstill |=> actual_scale <= $past(cfg.run_current_scale)) else $error("run cap");
  scale_event_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $changed(actual_scale) |-> scale_update) else $error("no update pulse");
  global_zero_a: assert property (@(posedge mclk) disable iff (!rst_n)
    cfg.global_current_scaler == 8'h00 |=> global_scale == CSV_GLOBAL_FULL) else $error("zero scaler");
  quiet_sel_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !cfg.quiet_mode_cfg |=> !mode.quiet_mode_en) else $error("quiet unconfigured");
  adapt_sel_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (fast_v[1] || !cfg.load_adapt_cfg) |=> !mode.load_adapt_en) else $error("adapt out of range");
  ramp_step_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (pd_state == CSV_RAMP && standstill && $past(pd_state) == CSV_RAMP && $changed(ramp_scale))
      |-> ramp_scale == $past(ramp_scale) - 5'h01) else $error("ramp step size");
endmodule : csv_current_mode

// *** test/csv_step_source.sv ***
// Partner model: step pulse source feeding the current and mode block
`timescale 1ns/1ps
module csv_step_source (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic enable, // Run steps while high
  input wire logic [19:0] period, // Clocks between pulses
  output logic step_pulse // One-cycle step event
);
  logic [19:0] cnt; // Clocks since last pulse
  ////////////////////////////////////////////////////////////////
  // One pulse every period clocks, quiet while disabled
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 20'h0_0000;
      step_pulse <= 1'b0;
    end else if (enable && cnt >= period - 20'h0_0001) begin
      cnt <= 20'h0_0000;
      step_pulse <= 1'b1;
    end else begin
      cnt <= enable ? cnt + 20'h0_0001 : 20'h0_0000;
      step_pulse <= 1'b0;
    end
  end
endmodule : csv_step_source

// *** test/tb_csv_current_mode.sv ***
// Testbench: current scaling and velocity mode selection
`timescale 1ns/1ps
module tb_csv_current_mode;
  import csv_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  csv_cfg_t cfg; // Block configuration
  logic step_en = 1'b0; // Partner step enable
  logic [19:0] period = 20'h0_0100; // Step period, 256 clocks
  logic [4:0] adapt_req = 5'h0a; // Load-adaptive request
  logic [7:0] sine = 8'hc8; // Sine table value
  logic step_pulse;
  logic [4:0] actual_scale;
  logic scale_update;
  logic [15:0] coil_current;
  logic [8:0] global_scale;
  logic standstill;
  logic [19:0] step_interval_measure;
  csv_mode_t mode;
  int fail_count = 0;
  int n_compared = 0;
  ////////////////////////////////////////////////////////////////
  // Clock and design hookup
  initial begin
    forever #5 mclk = ~mclk;
  end
  csv_current_mode csv_current_mode_i (.mclk(mclk), .rst_n(rst_n), .cfg(cfg), .step_pulse(step_pulse),
    .adapt_scale_req(adapt_req), .sine_value(sine), .actual_scale(actual_scale), .scale_update(scale_update),
    .coil_current(coil_current), .global_scale(global_scale), .standstill(standstill),
    .step_interval_measure(step_interval_measure), .mode(mode));
  csv_step_source csv_step_source_i (.mclk(mclk), .rst_n(rst_n), .enable(step_en), .period(period),
    .step_pulse(step_pulse));
  ////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic check(input logic [19:0] seen, input logic [19:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check
  task automatic wait_n(input int n);
    repeat (n) @(negedge mclk);
  endtask : wait_n
  function automatic logic [19:0] coil_exp(input logic [4:0] cs, input logic [8:0] g);
    logic [31:0] p;
    p = {24'h00_0000, sine} * ({27'h000_0000, cs} + 32'h0000_0001) * {23'h00_0000, g};
    return {4'h0, p[28:13]};
  endfunction : coil_exp
  task automatic set_lims(input logic [19:0] q, input logic [19:0] h, input logic [19:0] a,
    input logic qc, input logic lc);
    @(posedge mclk);
    cfg.quiet_mode_interval_limit <= q;
    cfg.high_speed_interval_limit <= h;
    cfg.load_adapt_interval_limit <= a;
    cfg.quiet_mode_cfg <= qc;
    cfg.load_adapt_cfg <= lc;
  endtask : set_lims
  task automatic report_and_stop;
    $display("Counts: %0d compared, %0d mismatched", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////////////////////////////
  // Reset values, hold scale at standstill, global scaler
  task automatic t_reset;
    wait_n(1);
    check(standstill, 20'h0_0001, "standstill in reset");
    check(step_interval_measure, 20'hf_ffff, "interval in reset");
    check(global_scale, 20'h0_0100, "scaler zero full");
    check(mode, 20'h0_0000, "mode in reset");
    @(posedge mclk);
    rst_n <= 1'b1;
    wait_n(20);
    check(actual_scale, cfg.hold_current_scale, "hold scale instant");
    check(coil_current, coil_exp(cfg.hold_current_scale, 9'h100), "hold coil");
    @(posedge mclk);
    cfg.global_current_scaler <= 8'h80;
    wait_n(5);
    check(global_scale, 20'h0_0080, "scaler value");
    check(coil_current, coil_exp(cfg.hold_current_scale, 9'h080), "coil at half scaler");
    $display("Test reset done");
  endtask : t_reset
  ////////////////////////////////////////////////////////////////
  // Running: run scale, interval measure, normalisation
  task automatic t_run;
    @(posedge mclk);
    step_en <= 1'b1;
    wait_n(3 * 256);
    check(standstill, 20'h0_0000, "standstill after steps");
    check(actual_scale, cfg.run_current_scale, "run scale");
    check(coil_current, coil_exp(cfg.run_current_scale, 9'h080), "run coil");
    check(step_interval_measure, 20'h0_0100, "interval 256");
    @(posedge mclk);
    cfg.mres <= 4'h2;
    wait_n(2 * 256);
    check(step_interval_measure, 20'h0_0040, "interval normalised");
    @(posedge mclk);
    cfg.mres <= 4'h0;
    wait_n(2 * 256);
    $display("Test run done");
  endtask : t_run
  ////////////////////////////////////////////////////////////////
  // Mode table at interval 256, and capped load-adaptive scale
  task automatic t_modes;
    logic [19:0] lim [5][3];
    logic [1:0] cf [5];
    logic [2:0] exp_mode [5];
    lim = '{'{20'd100, 20'd100, 20'd200}, '{20'd1000, 20'd100, 20'd1000}, '{20'd2000, 20'd1000, 20'd2000},
      '{20'd100, 20'd100, 20'd200}, '{20'd1000, 20'd100, 20'd1000}};
    cf = '{2'b11, 2'b11, 2'b11, 2'b01, 2'b10};
    exp_mode = '{3'b100, 3'b010, 3'b001, 3'b000, 3'b000};
    for (int k = 0; k < 5; k++) begin
      set_lims(lim[k][0], lim[k][1], lim[k][2], cf[k][1], cf[k][0]);
      wait_n(2 * 256);
      check(mode, exp_mode[k], "mode table");
      check(actual_scale, k == 1 ? adapt_req : cfg.run_current_scale, "adaptive scale");
    end
    set_lims(20'd1000, 20'd100, 20'd1000, 1'b0, 1'b1);
    wait_n(8);
    check(actual_scale, adapt_req, "adaptive honoured");
    @(posedge mclk);
    adapt_req <= 5'h19;
    wait_n(2);
    check(scale_update, 20'h0_0001, "update pulse on change");
    check(actual_scale, cfg.run_current_scale, "adaptive capped");
    wait_n(1);
    check(scale_update, 20'h0_0000, "update pulse one cycle");
    $display("Test modes done");
  endtask : t_modes
  ////////////////////////////////////////////////////////////////
  // Small and large hysteresis around the quiet-mode limit
  task automatic t_hyst;
    @(posedge mclk);
    cfg.small_hysteresis <= 1'b1;
    set_lims(20'd100, 20'd100, 20'd200, 1'b1, 1'b1);
    wait_n(2 * 256);
    set_lims(20'd260, 20'd100, 20'd200, 1'b1, 1'b1);
    wait_n(2 * 256);
    check(mode.quiet_mode_en, 20'h0_0001, "inside band stays slow");
    set_lims(20'd270, 20'd100, 20'd200, 1'b1, 1'b1);
    wait_n(2 * 256);
    check(mode.quiet_mode_en, 20'h0_0000, "above band goes fast");
    set_lims(20'd260, 20'd100, 20'd200, 1'b1, 1'b1);
    wait_n(2 * 256);
    check(mode.quiet_mode_en, 20'h0_0000, "inside band stays fast");
    set_lims(20'd256, 20'd100, 20'd200, 1'b1, 1'b1);
    wait_n(2 * 256);
    check(mode.quiet_mode_en, 20'h0_0001, "slow at threshold");
    @(posedge mclk);
    cfg.small_hysteresis <= 1'b0;
    set_lims(20'd270, 20'd100, 20'd200, 1'b1, 1'b1);
    wait_n(2 * 256);
    check(mode.quiet_mode_en, 20'h0_0001, "wide band stays slow");
    $display("Test hysteresis done");
  endtask : t_hyst
  ////////////////////////////////////////////////////////////////
  // Main sequence and watchdog
  initial begin
    cfg = '0;
    cfg.run_current_scale = 5'h14;
    cfg.hold_current_scale = 5'h08;
    repeat (3) @(posedge mclk);
    t_reset();
    t_run();
    t_modes();
    t_hyst();
    report_and_stop();
  end
  initial begin
    #(50000 * 10);
    fail_count++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    report_and_stop();
  end
endmodule : tb_csv_current_mode
